// file: logic/dphy_timing_pkg.sv
// Constants, enumerations and carrier types for the D-PHY timing register bank.
// Assumes a 32-bit APB master and a 12-bit byte address bus.
package dphy_timing_pkg;
	// Register indices as printed; the byte address is four times the index.
	localparam logic [9:0] IDX_CLK_POST = 10'h043;
	localparam logic [9:0] IDX_HS_PREPARE = 10'h044;
	localparam logic [9:0] IDX_HS_ZERO = 10'h045;
	localparam logic [9:0] IDX_HS_TRAIL = 10'h046;
	localparam logic [9:0] IDX_HS_EXIT = 10'h047;
	localparam logic [9:0] IDX_LP_PULSE = 10'h048;
	localparam int NUM_REGS = 6;
	localparam int ADDR_W = 12;
	// Field positions inside each register.
	localparam int SELECT_BIT = 7;
	localparam int COUNT_MSB = 6;
	// Counts after reset, valid for the 800 Mbps lane rate.
	localparam logic [6:0] RST_CLK_POST = 7'h0A;
	localparam logic [6:0] RST_HS_PREPARE = 7'h06;
	localparam logic [6:0] RST_HS_ZERO = 7'h0C;
	localparam logic [6:0] RST_HS_TRAIL = 7'h08;
	localparam logic [6:0] RST_HS_EXIT = 7'h0B;
	localparam logic [6:0] RST_LP_PULSE = 7'h06;
	localparam logic [5:0] RST_SELECT = 6'h00;
	// Lane rate choices; the code plus one is the rate in units of 400 Mbps.
	typedef enum logic [1:0] {
		RATE_400 = 2'h0,
		RATE_800 = 2'h1,
		RATE_1200 = 2'h2,
		RATE_1600 = 2'h3
	} lane_rate_t;
	localparam lane_rate_t RST_RATE = RATE_800;
	// Six counts, element 0 being the clock post time.
	typedef logic [NUM_REGS-1:0][6:0] count_vec_t;
	typedef struct packed {
		logic [6:0] lp_pulse;
		logic [6:0] hs_exit;
		logic [6:0] hs_trail;
		logic [6:0] hs_zero;
		logic [6:0] hs_prepare;
		logic [6:0] clk_post;
	} dphy_counts_t;
	localparam count_vec_t RST_COUNTS = {RST_LP_PULSE, RST_HS_EXIT, RST_HS_TRAIL,
		RST_HS_ZERO, RST_HS_PREPARE, RST_CLK_POST};
	// APB request and answer groups.
	typedef struct packed {
		logic psel;
		logic penable;
		logic pwrite;
		logic [ADDR_W-1:0] paddr;
		logic [31:0] pwdata;
	} apb_req_t;
	typedef struct packed {
		logic [31:0] prdata;
		logic pready;
		logic pslverr;
	} apb_rsp_t;
	// Whole state of the bank.
	typedef struct packed {
		logic [NUM_REGS-1:0] select;
		count_vec_t stored;
		count_vec_t derived;
		count_vec_t applied;
		lane_rate_t rate;
		logic [31:0] prdata;
		logic slverr;
	} bank_state_t;
endpackage

// file: logic/dphy_timing_regs.sv
// D-PHY timing override register bank for the first CSI-2 output port.
// Assumes an APB master on clk_i and a transmitter that flags idle gaps.
// Lane rate and idle flag come from logic on clk_i, so neither passes a synchroniser.
// How it works
// - The clock post register uses its own derived count while bit 7 is 0 and the written count while bit 7 is 1, resetting to count 0x0A with bit 7 clear.
// - The HS prepare register selects derived or written count by bit 7, count 0x6 after reset.
// - The HS zero register selects derived or written count by bit 7, count 0x0C after reset.
// - The HS trail register selects derived or written count by bit 7, count 0x8 after reset.
// - The HS exit register selects derived or written count by bit 7, count 0x0B after reset.
// - The LP pulse register selects derived or written count by bit 7, count 0x6 after reset.
// - With bit 7 clear, writes to bits 6:0 are ignored and reads return the derived count.
// - With bit 7 set, bits 6:0 take software writes and read back the stored value.
// - Derived counts reset to their 800 Mbps values and are recomputed when the lane rate changes.
//
// Register access over APB was left to the implementer.
`timescale 1ns/1ns
`default_nettype none
module dphy_timing_regs
(
	// Clock and reset.
	input wire logic clk_i,
	input wire logic rst_n_i,
	// APB slave.
	input wire dphy_timing_pkg::apb_req_t apb_i,
	output var dphy_timing_pkg::apb_rsp_t apb_o,
	// Lane rate choice and transmitter link.
	input wire dphy_timing_pkg::lane_rate_t lane_rate_i,
	input wire logic tx_idle_i,
	output var dphy_timing_pkg::dphy_counts_t timing_o
);
	dphy_timing_pkg::bank_state_t state_ff;
	dphy_timing_pkg::bank_state_t nxt_state;
	dphy_timing_pkg::count_vec_t effective;
	logic [9:0] word;
	logic hit;
	logic [2:0] sel;
	logic setup;
	logic wr_access;

	// Address decode; only word-aligned addresses inside the bank hit.
	assign word = apb_i.paddr[dphy_timing_pkg::ADDR_W-1:2];
	assign hit = (apb_i.paddr[1:0] == 2'h0) && (word >= dphy_timing_pkg::IDX_CLK_POST)
		&& (word <= dphy_timing_pkg::IDX_LP_PULSE);
	assign sel = 3'(word - dphy_timing_pkg::IDX_CLK_POST);
	assign setup = apb_i.psel && !apb_i.penable;
	assign wr_access = apb_i.psel && apb_i.penable && apb_i.pwrite;

	// Effective count per register: written when selected, else derived.
	always_comb
	begin
		for (int i = 0; i < dphy_timing_pkg::NUM_REGS; i++)
		begin
			effective[i] = state_ff.select[i] ? state_ff.stored[i] : state_ff.derived[i];
		end
	end

	// Next state of the whole bank.
	always_comb
	begin
		logic [7:0] scaled;
		scaled = 8'h00;
		nxt_state = state_ff;
		// The lane rate comes from logic on this clock and is taken as is.
		nxt_state.rate = lane_rate_i;
		// Scale the 800 Mbps counts by rate/800, rounding up.
		for (int i = 0; i < dphy_timing_pkg::NUM_REGS; i++)
		begin
			scaled = 8'(({1'b0, dphy_timing_pkg::RST_COUNTS[i]} * ({6'h00, state_ff.rate} + 8'h01)
				+ 8'h01) >> 1);
			nxt_state.derived[i] = scaled[6:0];
		end
		// Effective counts reach the transmitter only between transmissions.
		if (tx_idle_i)
		begin
			nxt_state.applied = effective;
		end
		// Register write at the access edge; the count lands only if selected.
		if (wr_access && hit)
		begin
			nxt_state.select[sel] = apb_i.pwdata[dphy_timing_pkg::SELECT_BIT];
			if (apb_i.pwdata[dphy_timing_pkg::SELECT_BIT])
			begin
				nxt_state.stored[sel] = apb_i.pwdata[dphy_timing_pkg::COUNT_MSB:0];
			end
		end
		// Read data and error are prepared in the setup cycle.
		if (setup)
		begin
			nxt_state.slverr = !hit;
			nxt_state.prdata = 32'h0000_0000;
			if (hit && !apb_i.pwrite)
			begin
				nxt_state.prdata = {24'h00_0000, state_ff.select[sel], effective[sel]};
			end
		end
	end

	// State register with synchronous reset.
	always_ff @(posedge clk_i)
	begin
		if (!rst_n_i)
		begin
			state_ff.select <= dphy_timing_pkg::RST_SELECT;
			state_ff.stored <= dphy_timing_pkg::RST_COUNTS;
			state_ff.derived <= dphy_timing_pkg::RST_COUNTS;
			state_ff.applied <= dphy_timing_pkg::RST_COUNTS;
			state_ff.rate <= dphy_timing_pkg::RST_RATE;
			state_ff.prdata <= 32'h0000_0000;
			state_ff.slverr <= 1'b0;
		end
		else
		begin
			state_ff <= nxt_state;
		end
	end

	// Outputs; ready is constant so every access takes one cycle.
	assign apb_o.prdata = state_ff.prdata;
	assign apb_o.pready = 1'b1;
	assign apb_o.pslverr = state_ff.slverr && apb_i.psel && apb_i.penable;
	assign timing_o = dphy_timing_pkg::dphy_counts_t'(state_ff.applied);

	// Checks on the bank behaviour.
	default clocking cb @(posedge clk_i);
	endclocking
	default disable iff (!rst_n_i);

	logic rd_access;
	assign rd_access = apb_i.psel && apb_i.penable && !apb_i.pwrite && hit;

	// Reset values, checked without the reset disable.
	a_reset_counts: assert property (disable iff (1'b0) !rst_n_i |=>
		(state_ff.select == 6'h00) && (state_ff.derived == dphy_timing_pkg::RST_COUNTS)
		&& (timing_o.clk_post == 7'h0A) && (timing_o.hs_zero == 7'h0C))
		else $error("Counts or selects wrong after reset.");

	// Reads with select clear return the derived count.
	a_read_auto: assert property (rd_access && !state_ff.select[sel] |->
		apb_o.prdata[6:0] == state_ff.derived[sel] && !apb_o.prdata[7])
		else $error("Auto read does not show derived count.");

	// Writes with select clear leave the stored count alone.
	a_write_ignored: assert property (wr_access && hit && !apb_i.pwdata[7]
		|=> state_ff.stored == $past(state_ff.stored) && !state_ff.select[$past(sel)])
		else $error("Count changed by write while automatic.");

	// Writes with select set store the count and read back.
	a_write_taken: assert property (wr_access && hit && apb_i.pwdata[7]
		|=> state_ff.stored[$past(sel)] == $past(apb_i.pwdata[6:0])
		&& effective[$past(sel)] == $past(apb_i.pwdata[6:0]))
		else $error("Overridden count not stored.");

	// Reads with select set return the stored value.
	a_read_override: assert property (rd_access && state_ff.select[sel] |->
		apb_o.prdata[7:0] == {1'b1, state_ff.stored[sel]})
		else $error("Override read does not show stored count.");

	// A held 1600 Mbps rate doubles the derived counts.
	a_rate_recompute: assert property (lane_rate_i == dphy_timing_pkg::RATE_1600 [*3]
		|-> state_ff.derived[0] == 7'h14 && state_ff.derived[2] == 7'h18)
		else $error("Derived counts not recomputed for new rate.");

	// Counts given to the transmitter hold during a transmission.
	a_apply_hold: assert property (!tx_idle_i |=> $stable(timing_o))
		else $error("Timing changed during a transmission.");

	// An idle gap hands over the effective counts.
	a_apply_take: assert property (tx_idle_i |=>
		state_ff.applied == $past(effective))
		else $error("Effective counts not applied at idle.");

	// Unmapped accesses answer with an error.
	a_unmapped_err: assert property (apb_i.psel && apb_i.penable && !hit |-> apb_o.pslverr)
		else $error("Unmapped access gave no error.");

	// Clock post count and select after reset.
	a_reset_clk_post: assert property (disable iff (1'b0) !rst_n_i |=>
		!state_ff.select[0] && (timing_o.clk_post == dphy_timing_pkg::RST_CLK_POST))
		else $error("Clock post count wrong after reset.");

	// HS prepare count and select after reset.
	a_reset_hs_prepare: assert property (disable iff (1'b0) !rst_n_i |=>
		!state_ff.select[1] && (timing_o.hs_prepare == dphy_timing_pkg::RST_HS_PREPARE))
		else $error("HS prepare count wrong after reset.");

	// HS zero count and select after reset.
	a_reset_hs_zero: assert property (disable iff (1'b0) !rst_n_i |=>
		!state_ff.select[2] && (timing_o.hs_zero == dphy_timing_pkg::RST_HS_ZERO))
		else $error("HS zero count wrong after reset.");

	// HS trail count and select after reset.
	a_reset_hs_trail: assert property (disable iff (1'b0) !rst_n_i |=>
		!state_ff.select[3] && (timing_o.hs_trail == dphy_timing_pkg::RST_HS_TRAIL))
		else $error("HS trail count wrong after reset.");

	// HS exit count and select after reset.
	a_reset_hs_exit: assert property (disable iff (1'b0) !rst_n_i |=>
		!state_ff.select[4] && (timing_o.hs_exit == dphy_timing_pkg::RST_HS_EXIT))
		else $error("HS exit count wrong after reset.");

	// LP pulse count and select after reset.
	a_reset_lp_pulse: assert property (disable iff (1'b0) !rst_n_i |=>
		!state_ff.select[5] && (timing_o.lp_pulse == dphy_timing_pkg::RST_LP_PULSE))
		else $error("LP pulse count wrong after reset.");

	// Read data and error flag are clear after reset.
	a_reset_outputs: assert property (disable iff (1'b0) !rst_n_i
		|=> apb_o.prdata == 32'h0000_0000 && !state_ff.slverr)
		else $error("Read data or error flag set after reset.");

	// Unmapped writes change no register.
	a_unmapped_write: assert property (wr_access && !hit
		|=> $stable(state_ff.select) && $stable(state_ff.stored))
		else $error("Unmapped write changed a register.");

	// Read data bits above the register are zero.
	a_rdata_upper: assert property (apb_i.psel && apb_i.penable
		|-> apb_o.prdata[31:8] == 24'h00_0000)
		else $error("Read data has bits set above bit 7.");

	// Unmapped accesses read as zero.
	a_unmapped_rdata: assert property (apb_i.psel && apb_i.penable && !hit
		|-> apb_o.prdata == 32'h0000_0000)
		else $error("Unmapped access returned nonzero data.");

	// Mapped accesses never answer with an error.
	a_mapped_no_err: assert property (apb_i.psel && apb_i.penable && hit
		|-> !apb_o.pslverr)
		else $error("Mapped access gave an error.");

	// Write accesses return zero read data.
	a_write_rdata_zero: assert property (apb_i.psel && apb_i.penable && apb_i.pwrite
		|-> apb_o.prdata == 32'h0000_0000)
		else $error("Write access returned nonzero data.");

	// The lane rate is registered once per clock.
	a_rate_taken: assert property (rst_n_i |=> state_ff.rate == $past(lane_rate_i))
		else $error("Lane rate not registered.");

	// A held 400 Mbps rate halves the derived counts, rounding up.
	a_derived_400: assert property ((lane_rate_i == dphy_timing_pkg::RATE_400) [*3]
		|-> state_ff.derived[1] == 7'h03 && state_ff.derived[4] == 7'h06)
		else $error("Derived counts wrong for 400 Mbps.");

	// A held 800 Mbps rate gives the counts after reset.
	a_derived_800: assert property ((lane_rate_i == dphy_timing_pkg::RATE_800) [*3]
		|-> state_ff.derived == dphy_timing_pkg::RST_COUNTS)
		else $error("Derived counts wrong for 800 Mbps.");

	// A held 1200 Mbps rate scales the derived counts by three halves.
	a_derived_1200: assert property ((lane_rate_i == dphy_timing_pkg::RATE_1200) [*3]
		|-> state_ff.derived[3] == 7'h0C && state_ff.derived[5] == 7'h09)
		else $error("Derived counts wrong for 1200 Mbps.");

	// A held 1600 Mbps rate doubles the HS prepare, HS trail and HS exit derived counts too.
	a_derived_1600: assert property ((lane_rate_i == dphy_timing_pkg::RATE_1600) [*3]
		|-> state_ff.derived[1] == 7'h0C && state_ff.derived[3] == 7'h10
		&& state_ff.derived[4] == 7'h16)
		else $error("Derived counts wrong for 1600 Mbps.");

	// A steady lane rate keeps the derived counts steady.
	a_derived_steady: assert property (rst_n_i && $stable(state_ff.rate)
		|=> $stable(state_ff.derived))
		else $error("Derived counts moved at a steady rate.");

	// Read data only changes in a setup cycle.
	a_rdata_hold: assert property (rst_n_i && !setup |=> $stable(apb_o.prdata))
		else $error("Read data changed outside a setup cycle.");

	// Selects and written counts change only on a mapped write.
	a_select_hold: assert property (rst_n_i && !(wr_access && hit)
		|=> $stable(state_ff.select) && $stable(state_ff.stored))
		else $error("Register changed without a mapped write.");

	// A mapped write sets the select bit from bit 7 of the data.
	a_write_select: assert property (wr_access && hit
		|=> state_ff.select[$past(sel)] == $past(apb_i.pwdata[dphy_timing_pkg::SELECT_BIT]))
		else $error("Select bit not taken from write data.");

	// A write leaves every register it does not address untouched.
	for (genvar g = 0; g < dphy_timing_pkg::NUM_REGS; g++)
	begin : g_isolate
		a_write_isolated: assert property (wr_access && hit && (sel != 3'(g))
			|=> $stable(state_ff.select[g]) && $stable(state_ff.stored[g]))
			else $error("Write reached a register it did not address.");
	end

	// An idle gap hands an overridden clock post count to the transmitter.
	a_idle_override: assert property (tx_idle_i && state_ff.select[0]
		|=> timing_o.clk_post == $past(state_ff.stored[0]))
		else $error("Overridden count not applied at idle.");

	// An idle gap hands a derived HS zero count to the transmitter.
	a_idle_auto: assert property (tx_idle_i && !state_ff.select[2]
		|=> timing_o.hs_zero == $past(state_ff.derived[2]))
		else $error("Derived count not applied at idle.");

	// Bit 7 of read data is the select bit of the addressed register.
	a_read_select: assert property (rd_access
		|-> apb_o.prdata[7] == state_ff.select[sel])
		else $error("Read select bit wrong.");

	// Main scenarios.
	c_override_write: cover property (wr_access && hit && apb_i.pwdata[7]);
	c_ignored_write: cover property (wr_access && hit && !apb_i.pwdata[7]);
	c_rate_change: cover property ($changed(state_ff.derived) ##[1:100] tx_idle_i);
	c_unmapped: cover property (apb_i.psel && apb_i.penable && !hit);
	c_idle_override: cover property (tx_idle_i && (state_ff.select != 6'h00));
endmodule // dphy_timing_regs
`default_nettype wire

// file: test/tb.sv
// Self-checking bench for the D-PHY timing register bank, driven over APB.
// Assumes the bank answers at once and takes new counts only in idle gaps.
`timescale 1ns/1ns
`default_nettype none
module tb;
	logic clk_i = 1'b0;
	logic rst_n_i = 1'b0;
	dphy_timing_pkg::apb_req_t req = '0;
	dphy_timing_pkg::apb_rsp_t apb_o;
	dphy_timing_pkg::lane_rate_t rate = dphy_timing_pkg::RATE_800;
	logic idle = 1'b0;
	dphy_timing_pkg::dphy_counts_t timing_o;
	int miscompares = 0;
	int num_checks = 0;
	logic [31:0] rd;
	logic err;
	dphy_timing_pkg::count_vec_t ov;
	dphy_timing_pkg::count_vec_t dv;
	logic [6:0] c;
	// Bank under test, every input driven by the bench.
	dphy_timing_regs DUT (.clk_i(clk_i), .rst_n_i(rst_n_i), .apb_i(req), .apb_o(apb_o),
		.lane_rate_i(rate), .tx_idle_i(idle), .timing_o(timing_o));
	// Clock of 100 ns period.
	always #50 clk_i = ~clk_i;
	// Compares one result and counts it.
	task automatic check(input string nm, input logic [41:0] exp, input logic [41:0] got);
		num_checks++;
		if (got !== exp)
		begin
			miscompares++;
			$display("FAIL %s expected %h seen %h", nm, exp, got);
		end
	endtask
	// One APB transfer: setup, access until pready, then release.
	task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] wd);
		int n;
		n = 0;
		@(posedge clk_i);
		req <= '{psel: 1'b1, penable: 1'b0, pwrite: wr, paddr: a, pwdata: wd};
		@(posedge clk_i);
		req.penable <= 1'b1;
		do
		begin
			@(posedge clk_i);
			n++;
		end
		while (apb_o.pready !== 1'b1 && n < 50);
		rd = apb_o.prdata;
		err = apb_o.pslverr;
		req <= '0;
		if (n >= 50)
			miscompares++;
	endtask
	// Byte address of register i of the bank.
	function automatic logic [11:0] ad(input int i);
		return {dphy_timing_pkg::IDX_CLK_POST + 10'(i), 2'b00};
	endfunction
	// Prints the counts and the verdict, then stops.
	task automatic final_report();
		$display("checks %0d mismatches %0d", num_checks, miscompares);
		if (miscompares == 0 && num_checks > 0)
			$display("Regression OK");
		else
			$display("Regression broken");
		$finish;
	endtask
	// Watchdog against a hung transfer.
	initial
	begin
		#400000;
		miscompares++;
		final_report();
	end
	// Main sequence of tests.
	initial
	begin
		repeat (20) @(posedge clk_i);
		rst_n_i <= 1'b1;
		check("timing", 42'(dphy_timing_pkg::RST_COUNTS), 42'(timing_o));
		for (int i = 0; i < 6; i++)
		begin
			ov[i] = 7'h20 + 7'(i);
			apb(1'b0, ad(i), 32'h0);
			check("reset", {35'h0, dphy_timing_pkg::RST_COUNTS[i]}, 42'(rd));
			apb(1'b1, ad(i), 32'h0000007F);
			apb(1'b0, ad(i), 32'h0);
			check("ignored", {35'h0, dphy_timing_pkg::RST_COUNTS[i]}, 42'(rd));
			apb(1'b1, ad(i), {24'h0, 1'b1, ov[i]});
			apb(1'b0, ad(i), 32'h0);
			check("override", {34'h0, 1'b1, ov[i]}, 42'(rd));
		end
		check("held", 42'(dphy_timing_pkg::RST_COUNTS), 42'(timing_o));
		@(posedge clk_i);
		idle <= 1'b1;
		@(posedge clk_i);
		idle <= 1'b0;
		@(posedge clk_i);
		check("applied", 42'(ov), 42'(timing_o));
		for (int i = 0; i < 6; i++)
			apb(1'b1, ad(i), 32'h0);
		// Each lane rate scales the derived counts.
		for (int r = 3; r >= 0; r--)
		begin
			rate <= dphy_timing_pkg::lane_rate_t'(r);
			repeat (3) @(posedge clk_i);
			for (int i = 0; i < 6; i++)
			begin
				c = dphy_timing_pkg::RST_COUNTS[i];
				dv[i] = 7'((int'(c) * (r + 1) + 1) / 2);
				apb(1'b0, ad(i), 32'h0);
				check("derived", {35'h0, dv[i]}, 42'(rd));
			end
		end
		@(posedge clk_i);
		idle <= 1'b1;
		@(posedge clk_i);
		idle <= 1'b0;
		@(posedge clk_i);
		check("derived_applied", 42'(dv), 42'(timing_o));
		apb(1'b1, 12'h124, 32'h000000FF);
		check("wr_err", 42'h1, 42'(err));
		apb(1'b0, 12'h10D, 32'h0);
		check("rd_err", 42'h100000000, {9'h0, err, rd});
		final_report();
	end
endmodule // tb
`default_nettype wire
